// ### src/supervisor_pkg.sv
// constants for the supply supervisor and watchdog
// assumes a 25 MHz system clock
package supervisor_pkg;
  localparam int unsigned CLK_HZ = 25000000;
  // reset hold choices in microseconds (1.4, 28, 200, 1600 ms)
  localparam int unsigned HOLD_OPT0_US = 1400;
  localparam int unsigned HOLD_OPT1_US = 28000;
  localparam int unsigned HOLD_OPT2_US = 200000;
  localparam int unsigned HOLD_OPT3_US = 1600000;
  localparam logic [1:0] HOLD_OPT_RESET = 2'h2;
  // watchdog timeout, plain default in microseconds
  localparam int unsigned WATCHDOG_TIMEOUT_US = 1600000;
  localparam longint unsigned US_PER_S = 1000000;
  localparam int unsigned CNT_W = 26;
  // cycles for a least time, rounded up
  function automatic int unsigned us_to_cycles(input int unsigned us);
    longint unsigned p;
    p = longint'(us) * longint'(CLK_HZ);
    return int'((p + US_PER_S - 1) / US_PER_S);
  endfunction
  localparam int unsigned HOLD_CYCLES_DEF = us_to_cycles(HOLD_OPT2_US);
  localparam int unsigned WATCHDOG_CYCLES_DEF = us_to_cycles(WATCHDOG_TIMEOUT_US);
  localparam logic [CNT_W-1:0] CNT_RESET = 26'h0;
endpackage

// ### src/sync_two_ff.sv
// two flip-flop synchroniser for a bank of pin levels
// assumes pins are asynchronous to clk_in
`timescale 1ns/1ps
module sync_two_ff #(
  parameter int unsigned WIDTH = 4,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic [WIDTH-1:0] async_in,
  output logic [WIDTH-1:0] sync_out
);
  typedef struct packed {
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
  } sync_state_t;
  sync_state_t state_q;
  sync_state_t state_d;
  always_comb begin
    state_d.meta = async_in;
    state_d.stable = state_q.meta;
  end
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_q <= {INIT, INIT};
    end else begin
      state_q <= state_d;
    end
  end
  assign sync_out = state_q.stable;
endmodule

// ### src/supply_supervisor_watchdog.sv
// supply supervisor with manual reset, watchdog, power fail and low line outputs
// assumes comparator results arrive as asynchronous digital levels
// Function
// R1 - a low manual reset input asserts the reset output
// R2 - any reset cause, watchdog included, gives a low pulse of one hold period
// R3 - reset held while supply low or manual reset active, then one hold period
// R4 - active high reset output is the exact inverse of the active low one
// R5 - power fail output low while sense input below its level, else high
// R6 - low line warning goes low when supply under the warning level
// R7 - processor toggles the kick input each timeout, else reset asserts
// R8 - reset held through power up, power down and brownout
// R9 - reset hold period chosen from four factory options
// R10 - watchdog restarts on every kick edge and on reset release
// R11 - watchdog and hold lengths fixed at build time
`timescale 1ns/1ps
module supply_supervisor_watchdog #(
  parameter logic [1:0] HOLD_OPT = supervisor_pkg::HOLD_OPT_RESET,
  parameter int unsigned WATCHDOG_CYCLES = supervisor_pkg::WATCHDOG_CYCLES_DEF
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic supply_low_in,
  input wire logic manual_reset_n_in,
  input wire logic power_fail_sense_low_in,
  input wire logic low_line_in,
  input wire logic watchdog_kick_in,
  output logic reset_n_out,
  output logic reset_out,
  output logic power_fail_flag_n_out,
  output logic low_line_warn_n_out
);
  localparam int unsigned W = supervisor_pkg::CNT_W;

  // maps the factory option code to a hold length in microseconds
  function automatic int unsigned hold_option_us(input logic [1:0] opt);
    case (opt)
      2'h0: return supervisor_pkg::HOLD_OPT0_US;
      2'h1: return supervisor_pkg::HOLD_OPT1_US;
      2'h2: return supervisor_pkg::HOLD_OPT2_US;
      2'h3: return supervisor_pkg::HOLD_OPT3_US;
      default: return supervisor_pkg::HOLD_OPT3_US;
    endcase
  endfunction

  // [R9] [R11]
  localparam int unsigned HOLD_US = hold_option_us(HOLD_OPT);
  localparam int unsigned HOLD_CYCLES = supervisor_pkg::us_to_cycles(HOLD_US);
  localparam logic [W-1:0] HOLD_LAST = W'(HOLD_CYCLES - 1);
  localparam logic [W-1:0] WD_LAST = W'(WATCHDOG_CYCLES - 1);

  // watchdog runs out when the last count is reached with no kick edge
  function automatic logic wd_expired(input logic [W-1:0] cnt, input logic kick_seen);
    return (cnt == WD_LAST) && !kick_seen;
  endfunction

  typedef enum logic [1:0] {
    ST_ASSERT = 2'h1,
    ST_RUN = 2'h2
  } sup_state_t;

  typedef struct packed {
    sup_state_t st;
    logic [W-1:0] hold_cnt;
    logic [W-1:0] wd_cnt;
    logic kick_prev;
    logic rst_n;
    logic pf_n;
    logic ll_n;
  } sup_regs_t;

  sup_regs_t r_q;
  sup_regs_t r_d;
  logic [4:0] pins_s;
  logic supply_low_s;
  logic mr_n_s;
  logic pf_low_s;
  logic low_line_s;
  logic kick_s;
  logic hold_cause;
  logic kick_edge;

  sync_two_ff #(
    .WIDTH(5),
    .INIT(5'h08)
  ) u_sync (
    .clk_in(clk_in),
    .rst_in(rst_in),
    .async_in({supply_low_in, manual_reset_n_in, power_fail_sense_low_in, low_line_in,
               watchdog_kick_in}),
    .sync_out(pins_s)
  );
  assign supply_low_s = pins_s[4];
  assign mr_n_s = pins_s[3];
  assign pf_low_s = pins_s[2];
  assign low_line_s = pins_s[1];
  assign kick_s = pins_s[0];

  // [R1] [R3] [R8]
  assign hold_cause = supply_low_s | ~mr_n_s;
  assign kick_edge = kick_s ^ r_q.kick_prev;

  always_comb begin
    r_d = r_q;
    r_d.kick_prev = kick_s;
    // [R5]
    r_d.pf_n = ~pf_low_s;
    // [R6]
    r_d.ll_n = ~(low_line_s | supply_low_s);
    case (r_q.st)
      ST_ASSERT: begin
        r_d.rst_n = 1'b0;
        r_d.wd_cnt = supervisor_pkg::CNT_RESET;
        if (hold_cause) begin
          // [R3]
          r_d.hold_cnt = supervisor_pkg::CNT_RESET;
        end else if (r_q.hold_cnt == HOLD_LAST) begin
          // [R2] [R10]
          r_d.st = ST_RUN;
          r_d.rst_n = 1'b1;
          r_d.hold_cnt = supervisor_pkg::CNT_RESET;
        end else begin
          r_d.hold_cnt = r_q.hold_cnt + W'(1);
        end
      end
      ST_RUN: begin
        r_d.rst_n = 1'b1;
        if (hold_cause || wd_expired(r_q.wd_cnt, kick_edge)) begin
          // [R1] [R7] [R2]
          r_d.st = ST_ASSERT;
          r_d.rst_n = 1'b0;
          r_d.hold_cnt = supervisor_pkg::CNT_RESET;
          r_d.wd_cnt = supervisor_pkg::CNT_RESET;
        end else if (kick_edge) begin
          // [R10]
          r_d.wd_cnt = supervisor_pkg::CNT_RESET;
        end else begin
          r_d.wd_cnt = r_q.wd_cnt + W'(1);
        end
      end
      default: begin
        r_d.st = ST_ASSERT;
        r_d.rst_n = 1'b0;
        r_d.hold_cnt = supervisor_pkg::CNT_RESET;
        r_d.wd_cnt = supervisor_pkg::CNT_RESET;
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      // [R8]
      r_q <= '{st: ST_ASSERT, hold_cnt: supervisor_pkg::CNT_RESET,
               wd_cnt: supervisor_pkg::CNT_RESET, kick_prev: 1'b0,
               rst_n: 1'b0, pf_n: 1'b1, ll_n: 1'b1};
    end else begin
      r_q <= r_d;
    end
  end

  assign reset_n_out = r_q.rst_n;
  // [R4]
  assign reset_out = ~r_q.rst_n;
  assign power_fail_flag_n_out = r_q.pf_n;
  assign low_line_warn_n_out = r_q.ll_n;

  // assertions
  sequence s_cause_gone;
    !hold_cause ##1 !hold_cause;
  endsequence

  a_manual_reset_low: assert property (@(posedge clk_in) disable iff (rst_in) // [R1]
    !mr_n_s |=> !reset_n_out) else $error("manual reset did not assert reset");
  a_reset_pulse_held: assert property (@(posedge clk_in) disable iff (rst_in) // [R2]
    $fell(reset_n_out) |-> !reset_n_out [*8]) else $error("reset pulse too short");
  a_hold_cause_kept: assert property (@(posedge clk_in) disable iff (rst_in) // [R3]
    hold_cause |=> !reset_n_out ##1 (hold_cause or !reset_n_out)) else $error("reset dropped");
  a_release_after_hold: assert property (@(posedge clk_in) disable iff (rst_in) // [R3]
    $rose(reset_n_out) |-> $past(r_q.hold_cnt) == HOLD_LAST) else $error("early release");
  a_high_inverse: assert property (@(posedge clk_in) disable iff (rst_in) // [R4]
    reset_out == !reset_n_out) else $error("reset outputs not inverse");
  a_power_fail_out: assert property (@(posedge clk_in) disable iff (rst_in) // [R5]
    pf_low_s |=> !power_fail_flag_n_out) else $error("power fail flag not low");
  a_low_line_out: assert property (@(posedge clk_in) disable iff (rst_in) // [R6]
    low_line_s |=> !low_line_warn_n_out) else $error("low line not low");
  a_watchdog_expiry: assert property (@(posedge clk_in) disable iff (rst_in) // [R7]
    (r_q.st == ST_RUN && wd_expired(r_q.wd_cnt, kick_edge)) |=> !reset_n_out)
    else $error("watchdog expiry missed");
  a_kick_restart: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
    (r_q.st == ST_RUN && kick_edge && !hold_cause) |=> r_q.wd_cnt == '0)
    else $error("kick did not restart watchdog");
  a_supply_low_reset: assert property (@(posedge clk_in) disable iff (rst_in) // [R8]
    supply_low_s |=> !reset_n_out) else $error("brownout did not hold reset");

  // hold phase counting
  sequence s_hold_done;
    r_q.st == ST_ASSERT && !hold_cause && r_q.hold_cnt == HOLD_LAST;
  endsequence

  a_hold_restart: assert property (@(posedge clk_in) disable iff (rst_in) // [R3]
    (r_q.st == ST_ASSERT && hold_cause) |=> r_q.hold_cnt == '0)
    else $error("hold count not restarted by cause");
  a_hold_advance: assert property (@(posedge clk_in) disable iff (rst_in) // [R2]
    (r_q.st == ST_ASSERT && !hold_cause && r_q.hold_cnt != HOLD_LAST)
    |=> r_q.hold_cnt == $past(r_q.hold_cnt) + W'(1))
    else $error("hold count did not advance");
  a_hold_progress: assert property (@(posedge clk_in) disable iff (rst_in) // [R3]
    (r_q.st == ST_ASSERT ##0 s_cause_gone) |-> (r_q.hold_cnt != '0 || r_q.st == ST_RUN))
    else $error("hold phase stalled without a cause");
  a_hold_release: assert property (@(posedge clk_in) disable iff (rst_in) // [R2]
    s_hold_done |=> reset_n_out) else $error("reset not released after hold");
  a_run_released: assert property (@(posedge clk_in) disable iff (rst_in) // [R2]
    r_q.st == ST_RUN |-> reset_n_out) else $error("reset low in run state");
  a_kick_ignored: assert property (@(posedge clk_in) disable iff (rst_in) // [R10]
    r_q.st == ST_ASSERT |=> r_q.wd_cnt == '0) else $error("watchdog ran during reset");
  a_power_fail_high: assert property (@(posedge clk_in) disable iff (rst_in) // [R5]
    !pf_low_s |=> power_fail_flag_n_out) else $error("power fail flag not high");
  a_low_line_high: assert property (@(posedge clk_in) disable iff (rst_in) // [R6]
    (!low_line_s && !supply_low_s) |=> low_line_warn_n_out) else $error("low line not high");
  a_state_onehot: assert property (@(posedge clk_in) disable iff (rst_in) // [R8]
    $onehot(r_q.st)) else $error("state not one hot");
endmodule

// ### dv/cpu_supply_model.sv
// processor side model: toggles the watchdog kick input at a set spacing
// assumes the bench enables it only when kicks are wanted
`timescale 1ns/1ps
module cpu_supply_model (
  input wire logic clk_in,
  input wire logic kick_enable_in,
  input wire logic [7:0] kick_gap_in,
  output logic kick_out
);
  int cnt = 0;
  logic kick_q = 1'b0;
  assign kick_out = kick_q;
  // the kick level is held for a whole gap, so every edge is seen
  always @(posedge clk_in) begin
    #1;
    if (kick_enable_in) begin
      cnt++;
      if (cnt >= int'(kick_gap_in)) begin
        cnt = 0;
        kick_q = ~kick_q;
      end
    end else begin
      cnt = 0;
    end
  end
endmodule

// ### dv/tb_supply_supervisor_watchdog.sv
// self-checking bench for the supply supervisor and watchdog
// assumes a 25 MHz clock and the shortest reset hold option
`timescale 1ns/1ps
module tb_supply_supervisor_watchdog;
  localparam int HOLD = supervisor_pkg::HOLD_OPT0_US * 25;
  localparam int WD = 50;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  logic supply_low_in = 1'b0;
  logic manual_reset_n_in = 1'b1;
  logic power_fail_sense_low_in = 1'b0;
  logic low_line_in = 1'b0;
  logic kick_en = 1'b0;
  logic [7:0] kick_gap = 8'h0A;
  logic watchdog_kick_in;
  logic reset_n_out, reset_out, power_fail_flag_n_out, low_line_warn_n_out;
  logic [15:0] lfsr_q = 16'h4FD6;
  int bad_count = 0;
  int total_checks = 0;
  int low_len;
  always #20 clk_in = ~clk_in;
  supply_supervisor_watchdog #(.HOLD_OPT(2'h0), .WATCHDOG_CYCLES(WD)) supply_supervisor_watchdog_i (
    .clk_in(clk_in), .rst_in(rst_in), .supply_low_in(supply_low_in),
    .manual_reset_n_in(manual_reset_n_in), .power_fail_sense_low_in(power_fail_sense_low_in),
    .low_line_in(low_line_in), .watchdog_kick_in(watchdog_kick_in),
    .reset_n_out(reset_n_out), .reset_out(reset_out),
    .power_fail_flag_n_out(power_fail_flag_n_out), .low_line_warn_n_out(low_line_warn_n_out));
  cpu_supply_model cpu_supply_model_i (.clk_in(clk_in), .kick_enable_in(kick_en),
    .kick_gap_in(kick_gap), .kick_out(watchdog_kick_in));
  function automatic logic [15:0] lfsr_next(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  task automatic step(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic chk(input string what, input logic e, input logic s);
    total_checks++;
    if (s !== e) begin
      bad_count++;
      $display("unexpected %s expected %b seen %b", what, e, s);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  initial begin
    #(40 * 80000);
    bad_count++;
    print_verdict();
  end
  initial begin
    step(10);
    rst_in = 1'b0;
    step(3);
    chk("reset_n_out", 1'b0, reset_n_out);
    for (int i = 0; i < 8; i++) begin
      lfsr_q = lfsr_next(lfsr_q);
      power_fail_sense_low_in = lfsr_q[0];
      low_line_in = lfsr_q[1];
      step(4);
      chk("power_fail_flag_n_out", ~lfsr_q[0], power_fail_flag_n_out);
      chk("low_line_warn_n_out", ~lfsr_q[1], low_line_warn_n_out);
    end
    power_fail_sense_low_in = 1'b0;
    low_line_in = 1'b0;
    manual_reset_n_in = 1'b0;
    step(5);
    chk("reset_n_out", 1'b0, reset_n_out);
    chk("reset_out", 1'b1, reset_out);
    supply_low_in = 1'b1;
    step(5);
    chk("low_line_warn_n_out", 1'b0, low_line_warn_n_out);
    manual_reset_n_in = 1'b1;
    step(30);
    chk("reset_n_out", 1'b0, reset_n_out);
    supply_low_in = 1'b0;
    step(HOLD - 10);
    chk("reset_n_out", 1'b0, reset_n_out);
    step(20);
    chk("reset_n_out", 1'b1, reset_n_out);
    chk("reset_out", 1'b0, reset_out);
    kick_en = 1'b1;
    step(200);
    chk("reset_n_out", 1'b1, reset_n_out);
    kick_gap = 8'h28;
    step(200);
    chk("reset_n_out", 1'b1, reset_n_out);
    kick_en = 1'b0;
    repeat (WD + 90) if (reset_n_out === 1'b1) step(1);
    chk("reset_n_out", 1'b0, reset_n_out);
    low_len = 0;
    while (reset_n_out === 1'b0 && low_len < HOLD + 100) begin
      step(1);
      low_len++;
    end
    chk("hold length", 1'b1, logic'(low_len >= HOLD - 5 && low_len <= HOLD + 5));
    print_verdict();
  end
endmodule
